// >>> hw/tfr_pkg.sv
package tfr_pkg;
  // link register selects
  localparam logic [3:0] SEL_DATA     = 4'h0;
  localparam logic [3:0] SEL_ERR_FEAT = 4'h1;
  localparam logic [3:0] SEL_COUNT    = 4'h2;
  localparam logic [3:0] SEL_SECNUM   = 4'h3;
  localparam logic [3:0] SEL_CYL_LO   = 4'h4;
  localparam logic [3:0] SEL_CYL_HI   = 4'h5;
  localparam logic [3:0] SEL_DRVHEAD  = 4'h6;
  localparam logic [3:0] SEL_STAT_CMD = 4'h7;
  localparam logic [3:0] SEL_AUX_CTL  = 4'h8;
  localparam logic [3:0] SEL_DRV_ADDR = 4'h9;
  localparam int         TF_FIRST     = 2;
  localparam int         TF_LAST      = 6;
  // error cause bits
  localparam int ERR_BBK  = 7;
  localparam int ERR_UNC  = 6;
  localparam int ERR_SECTOR_ID_MISSING_FLAG = 4;
  localparam int ERR_COMMAND_ABORT_FLAG = 2;
  localparam int ERR_GENERAL_ERROR_FLAG = 0;
  // drive/head bits
  localparam int DH_ONE_HI = 7;
  localparam int DH_LBA    = 6;
  localparam int DH_ONE_LO = 5;
  localparam int DH_DRV    = 4;
  // device control bits
  localparam int CTL_HOB  = 7;
  localparam int CTL_SRST = 2;
  localparam int CTL_NIEN = 1;
  // status bits
  localparam int STAT_BUSY = 7;
  // reset values
  localparam logic [7:0] DH_RESET  = 8'ha0;
  localparam logic [7:0] TF_RESET  = 8'h00;
  localparam logic [7:0] ERR_RESET = 8'h00;
  // sector transfer
  localparam int         PTR_W       = 8;
  localparam logic [7:0] PTR_LAST    = 8'hff;
  localparam logic [8:0] ZERO_COUNT  = 9'h100;
  localparam logic [8:0] ONE_SECTOR  = 9'h001;
  localparam logic [7:0] CMD_READ_A  = 8'h20;
  localparam logic [7:0] CMD_READ_B  = 8'h21;
  localparam logic [7:0] CMD_WRITE_A = 8'h30;
  localparam logic [7:0] CMD_WRITE_B = 8'h31;
  // host-side register map
  localparam int         HADDR_W     = 4;
  localparam logic [3:0] HOFS_ISSUE  = 4'h0;
  localparam logic [3:0] HOFS_RESULT = 4'h4;
  localparam int         ISSUE_RD    = 8;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_EXEC  = 4'h2,
    ST_DRQ   = 4'h4,
    ST_FLUSH = 4'h8
  } tfr_state_t;

  function automatic logic tfr_is_read(input logic [7:0] code);
    return (code == CMD_READ_A) || (code == CMD_READ_B);
  endfunction

  function automatic logic tfr_is_write(input logic [7:0] code);
    return (code == CMD_WRITE_A) || (code == CMD_WRITE_B);
  endfunction
endpackage // tfr_pkg

// >>> hw/tfr_link_if.sv
interface tfr_link_if;
  logic [3:0]  tf_sel;
  logic        tf_wr;
  logic        tf_rd;
  logic [15:0] tf_wdata;
  logic [15:0] tf_rdata;
  logic        tf_ack;
  logic        tf_intrq;

  modport host_mp (
    output tf_sel, tf_wr, tf_rd, tf_wdata,
    input  tf_rdata, tf_ack, tf_intrq
  );

  modport dev_mp (
    input  tf_sel, tf_wr, tf_rd, tf_wdata,
    output tf_rdata, tf_ack, tf_intrq
  );
endinterface // tfr_link_if

// >>> hw/tfr_sector_buf.sv
module tfr_sector_buf (
  // clock
  input  wire logic        core_clk,
  // write port
  input  wire logic        we,
  input  wire logic [7:0]  waddr,
  input  wire logic [15:0] wdata,
  // read ports
  input  wire logic [7:0]  raddr_a,
  output logic      [15:0] rdata_a,
  input  wire logic [7:0]  raddr_b,
  output logic      [15:0] rdata_b
);
  logic [15:0] mem [0:255];

  always_ff @(posedge core_clk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
  end

  assign rdata_a = mem[raddr_a];
  assign rdata_b = mem[raddr_b];
endmodule // tfr_sector_buf

// >>> hw/tfr_device_end.sv
// What this block does
// - 16-bit data port moves sector buffer blocks
// - error register bit layout, reserved bits zero
// - error cause valid only with status error
// - abort bit on not ready, fault, invalid
// - zero sector count means 256 sectors
// - count zero on success, remainder on failure
// - LBA built from four address registers
// - drive/head bit 6 selects LBA or CHS
// - host writes bits 7,5 one, drive zero
// - status read clears interrupt, aux read not
// - busy locks host out of command, buffer
// - ready clear from reset until able
// - write fault flag; seek complete when ready
// - data request while data must move
// - corrected error flag, read continues
// - index reads zero; error flag after failure
// - high-order readback bit, cleared by writes
// - soft reset held while control bit set
// - interrupt disable bit, zero after reset
// - control bits 3,0 and 6-4 ignored
// - drive address register readback layout
// - host avoids legacy drive address register
module tfr_device_end (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // task-file link
  tfr_link_if.dev_mp       lnk,
  // back end condition
  input  wire logic        be_ready,
  input  wire logic        be_wfault,
  // back end step answer
  input  wire logic        be_done,
  input  wire logic [4:0]  be_err,
  input  wire logic        be_corrected_error_flag,
  // back end buffer access
  input  wire logic        be_fill_we,
  input  wire logic [7:0]  be_fill_addr,
  input  wire logic [15:0] be_fill_data,
  input  wire logic [7:0]  be_drain_addr,
  output logic      [15:0] be_drain_data,
  // back end step request
  output logic             be_req,
  output logic      [7:0]  be_cmd_code,
  output logic      [27:0] be_lba,
  output logic             be_lba_mode,
  output logic      [7:0]  be_feature
);
  import tfr_pkg::*;

  tfr_state_t  state_q;
  tfr_state_t  state_d;
  logic [7:0]  tf_q      [TF_FIRST:TF_LAST];
  logic [7:0]  tf_prev_q [TF_FIRST:TF_LAST];
  logic [7:0]  feat_q;
  logic [7:0]  cmd_q;
  logic [7:0]  err_q;
  logic        stat_err_q;
  logic        corrected_error_flag_q;
  logic        wfault_q;
  logic        rdy_q;
  logic        hob_q;
  logic        srst_q;
  logic        nien_q;
  logic        irq_q;
  logic        rd_kind_q;
  logic        wr_kind_q;
  logic [8:0]  remain_q;
  logic [7:0]  ptr_q;
  logic        req_q;
  logic        ack_q;
  logic [15:0] rdata_q;
  logic [15:0] drain_q;
  logic        req_d;
  logic        fin_d;
  logic        dec_d;
  logic [7:0]  rd_byte;

  // decode of link accesses
  wire        busy      = (state_q == ST_EXEC) | (state_q == ST_FLUSH) | srst_q;
  wire        drq       = (state_q == ST_DRQ);
  wire        cb_wr     = lnk.tf_wr & (lnk.tf_sel <= SEL_STAT_CMD) & ~busy;
  wire        cmd_go    = cb_wr & (lnk.tf_sel == SEL_STAT_CMD) & (state_q == ST_IDLE);
  wire        abort_now = cmd_go & (~rdy_q | wfault_q);
  wire        ctl_wr    = lnk.tf_wr & (lnk.tf_sel == SEL_AUX_CTL);
  wire        stat_rd   = lnk.tf_rd & (lnk.tf_sel == SEL_STAT_CMD);
  wire        data_sel  = (lnk.tf_sel == SEL_DATA) & drq;
  wire        data_wr   = data_sel & lnk.tf_wr & wr_kind_q;
  wire        data_rd   = data_sel & lnk.tf_rd & rd_kind_q;
  wire        last_word = (data_wr | data_rd) & (ptr_q == PTR_LAST);
  wire        blk_bad   = be_done & ((be_err != 5'h00) | be_wfault);
  wire [7:0]  new_err   = {be_err[4], be_err[3], 1'b0, be_err[2], 1'b0,
                           be_err[1] | be_wfault, 1'b0, be_err[0]};
  wire [8:0]  rem_next  = dec_d ? (remain_q - ONE_SECTOR) : remain_q;
  wire [7:0]  status    = {busy, rdy_q, wfault_q, rdy_q, drq, corrected_error_flag_q, 1'b0,
                           stat_err_q};
  wire        wr_active = wr_kind_q & ((state_q == ST_DRQ) | (state_q == ST_FLUSH));
  wire        drq_entry = (state_d == ST_DRQ) & (state_q != ST_DRQ);
  wire        irq_set   = (fin_d | drq_entry) & ~nien_q;
  wire [15:0] buf_a;
  wire [15:0] buf_b;
  wire [7:0]  dh        = tf_q[TF_LAST];

  // sector buffer: host side at the word pointer, back end at its own address
  tfr_sector_buf u_buf (
    .core_clk (core_clk),
    .we       (data_wr | be_fill_we),
    .waddr    (data_wr ? ptr_q : be_fill_addr),
    .wdata    (data_wr ? lnk.tf_wdata : be_fill_data),
    .raddr_a  (ptr_q),
    .rdata_a  (buf_a),
    .raddr_b  (be_drain_addr),
    .rdata_b  (buf_b)
  );

  // command sequencing
  always_comb
  begin
    state_d = state_q;
    req_d   = 1'b0;
    fin_d   = 1'b0;
    dec_d   = 1'b0;
    case (state_q)
      ST_IDLE:
        if (cmd_go)
        begin
          if (abort_now)
            fin_d = 1'b1;
          else if (tfr_is_write(lnk.tf_wdata[7:0]))
            state_d = ST_DRQ;
          else
          begin
            state_d = ST_EXEC;
            req_d   = 1'b1;
          end
        end
      ST_EXEC:
        if (be_done)
        begin
          if (blk_bad | ~rd_kind_q)
          begin
            state_d = ST_IDLE;
            fin_d   = 1'b1;
          end
          else
            state_d = ST_DRQ;
        end
      ST_DRQ:
        if (last_word)
        begin
          if (wr_kind_q)
          begin
            state_d = ST_FLUSH;
            req_d   = 1'b1;
          end
          else
          begin
            dec_d = 1'b1;
            if (remain_q == ONE_SECTOR)
            begin
              state_d = ST_IDLE;
              fin_d   = 1'b1;
            end
            else
            begin
              state_d = ST_EXEC;
              req_d   = 1'b1;
            end
          end
        end
      ST_FLUSH:
        if (be_done)
        begin
          if (blk_bad)
          begin
            state_d = ST_IDLE;
            fin_d   = 1'b1;
          end
          else
          begin
            dec_d = 1'b1;
            if (remain_q == ONE_SECTOR)
            begin
              state_d = ST_IDLE;
              fin_d   = 1'b1;
            end
            else
              state_d = ST_DRQ;
          end
        end
      default:
        state_d = ST_IDLE;
    endcase
    if (srst_q)
    begin
      state_d = ST_IDLE;
      req_d   = 1'b0;
      fin_d   = 1'b0;
      dec_d   = 1'b0;
    end
  end

  // register readback
  always_comb
  begin
    case (lnk.tf_sel)
      SEL_ERR_FEAT: rd_byte = err_q;
      SEL_COUNT:    rd_byte = hob_q ? tf_prev_q[2] : tf_q[2];
      SEL_SECNUM:   rd_byte = hob_q ? tf_prev_q[3] : tf_q[3];
      SEL_CYL_LO:   rd_byte = hob_q ? tf_prev_q[4] : tf_q[4];
      SEL_CYL_HI:   rd_byte = hob_q ? tf_prev_q[5] : tf_q[5];
      SEL_DRVHEAD:  rd_byte = hob_q ? tf_prev_q[6] : tf_q[6];
      SEL_STAT_CMD: rd_byte = status;
      SEL_AUX_CTL:  rd_byte = status;
      SEL_DRV_ADDR: rd_byte = {1'b0, ~wr_active, ~dh[3:0], 2'b10};
      default:      rd_byte = 8'h00;
    endcase
  end

  // link answer
  always_ff @(posedge core_clk)
  begin
    ack_q   <= rst_n & lnk.tf_rd;
    rdata_q <= (lnk.tf_sel == SEL_DATA) ? buf_a : {8'h00, rd_byte};
    drain_q <= buf_b;
    req_q   <= rst_n & req_d;
  end

  // task-file registers
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      for (int i = TF_FIRST; i <= TF_LAST; i++)
      begin
        tf_q[i]      <= (i == TF_LAST) ? DH_RESET : TF_RESET;
        tf_prev_q[i] <= (i == TF_LAST) ? DH_RESET : TF_RESET;
      end
      feat_q <= TF_RESET;
      cmd_q  <= TF_RESET;
      hob_q  <= 1'b0;
      srst_q <= 1'b0;
      nien_q <= 1'b0;
    end
    else
    begin
      for (int i = TF_FIRST; i <= TF_LAST; i++)
      begin
        if (cb_wr && lnk.tf_sel == 4'(i))
        begin
          tf_prev_q[i] <= tf_q[i];
          tf_q[i]      <= lnk.tf_wdata[7:0];
        end
      end
      if (fin_d && (rd_kind_q || wr_kind_q))
        tf_q[TF_FIRST] <= rem_next[7:0];
      if (cb_wr && lnk.tf_sel == SEL_ERR_FEAT)
        feat_q <= lnk.tf_wdata[7:0];
      if (cmd_go)
        cmd_q <= lnk.tf_wdata[7:0];
      if (cb_wr)
        hob_q <= 1'b0;
      else if (ctl_wr)
        hob_q <= lnk.tf_wdata[CTL_HOB];
      if (ctl_wr)
      begin
        srst_q <= lnk.tf_wdata[CTL_SRST];
        nien_q <= lnk.tf_wdata[CTL_NIEN] & ~lnk.tf_wdata[CTL_SRST];
      end
    end
  end

  // command progress and status
  always_ff @(posedge core_clk)
  begin
    if (!rst_n || srst_q)
    begin
      state_q    <= ST_IDLE;
      err_q      <= ERR_RESET;
      stat_err_q <= 1'b0;
      corrected_error_flag_q     <= 1'b0;
      rdy_q      <= 1'b0;
      wfault_q   <= 1'b0;
      irq_q      <= 1'b0;
      rd_kind_q  <= 1'b0;
      wr_kind_q  <= 1'b0;
      remain_q   <= ZERO_COUNT;
      ptr_q      <= 8'h00;
    end
    else
    begin
      state_q  <= state_d;
      rdy_q    <= be_ready;
      wfault_q <= be_wfault;
      irq_q    <= irq_set | (irq_q & ~stat_rd & ~nien_q);
      if (cmd_go)
      begin
        err_q      <= ERR_RESET;
        stat_err_q <= 1'b0;
        corrected_error_flag_q     <= 1'b0;
        rd_kind_q  <= ~abort_now & tfr_is_read(lnk.tf_wdata[7:0]);
        wr_kind_q  <= ~abort_now & tfr_is_write(lnk.tf_wdata[7:0]);
        remain_q   <= (tf_q[TF_FIRST] == 8'h00) ? ZERO_COUNT
                                                : {1'b0, tf_q[TF_FIRST]};
      end
      else
        remain_q <= rem_next;
      if (abort_now)
      begin
        err_q               <= ERR_RESET;
        err_q[ERR_COMMAND_ABORT_FLAG]     <= 1'b1;
        stat_err_q          <= 1'b1;
      end
      else if (fin_d && blk_bad)
      begin
        err_q      <= new_err;
        stat_err_q <= 1'b1;
      end
      if (be_done && be_corrected_error_flag)
        corrected_error_flag_q <= 1'b1;
      if (drq_entry)
        ptr_q <= 8'h00;
      else if (data_wr || data_rd)
        ptr_q <= ptr_q + 8'h01;
    end
  end

  assign lnk.tf_rdata   = rdata_q;
  assign lnk.tf_ack     = ack_q;
  assign lnk.tf_intrq   = irq_q;
  assign be_req         = req_q;
  assign be_drain_data  = drain_q;
  assign be_cmd_code    = cmd_q;
  assign be_lba         = {dh[3:0], tf_q[5], tf_q[4], tf_q[3]};
  assign be_lba_mode    = dh[DH_LBA];
  assign be_feature     = feat_q;
endmodule // tfr_device_end

// >>> hw/tfr_host_end.sv
module tfr_host_end (
  // clock and reset
  input  wire logic                         core_clk,
  input  wire logic                         rst_n,
  // axi4-lite write
  input  wire logic                         s_axi_awvalid,
  output logic                              s_axi_awready,
  input  wire logic [tfr_pkg::HADDR_W-1:0]  s_axi_awaddr,
  input  wire logic                         s_axi_wvalid,
  output logic                              s_axi_wready,
  input  wire logic [31:0]                  s_axi_wdata,
  input  wire logic [3:0]                   s_axi_wstrb,
  output logic                              s_axi_bvalid,
  input  wire logic                         s_axi_bready,
  output logic      [1:0]                   s_axi_bresp,
  // axi4-lite read
  input  wire logic                         s_axi_arvalid,
  output logic                              s_axi_arready,
  input  wire logic [tfr_pkg::HADDR_W-1:0]  s_axi_araddr,
  output logic                              s_axi_rvalid,
  input  wire logic                         s_axi_rready,
  output logic      [31:0]                  s_axi_rdata,
  output logic      [1:0]                   s_axi_rresp,
  // task-file link
  tfr_link_if.host_mp                       lnk
);
  import tfr_pkg::*;

  logic        awready_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        arready_q;
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;
  logic [31:0] issue_q;
  logic        pend_q;
  logic        refused_q;
  logic [7:0]  stat_seen_q;
  logic [15:0] tf_rdata_q;
  logic [3:0]  sel_q;
  logic        wr_q;
  logic        rd_q;
  logic [15:0] wd_q;

  // bus decode
  wire        w_take    = s_axi_awvalid & s_axi_wvalid & ~awready_q & ~bvalid_q;
  wire        r_take    = s_axi_arvalid & ~arready_q & ~rvalid_q;
  wire        w_issue   = w_take & (s_axi_awaddr == HOFS_ISSUE) & (s_axi_wstrb == 4'hf);
  wire        w_ok      = w_take & (s_axi_awaddr == HOFS_ISSUE);
  wire        r_ok      = (s_axi_araddr == HOFS_ISSUE) | (s_axi_araddr == HOFS_RESULT);
  wire [31:0] result    = {tf_rdata_q, stat_seen_q, 5'h00, lnk.tf_intrq, refused_q, pend_q};
  // access screening
  wire [3:0]  new_sel   = s_axi_wdata[3:0];
  wire        new_rd    = s_axi_wdata[ISSUE_RD];
  wire        dev_busy  = stat_seen_q[STAT_BUSY];
  wire        locked    = dev_busy & ((new_sel == SEL_DATA) |
                                      (~new_rd & (new_sel == SEL_STAT_CMD)));
  wire        allowed   = ~pend_q & ~locked & (new_sel != SEL_DRV_ADDR);
  wire        go        = w_issue & allowed;
  wire [15:0] dh_fixed  = {s_axi_wdata[31:24], 1'b1, s_axi_wdata[22], 1'b1, 1'b0,
                           s_axi_wdata[19:16]};
  wire [15:0] new_wd    = (new_sel == SEL_DRVHEAD) ? dh_fixed : s_axi_wdata[31:16];

  // bus slave
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      awready_q <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= RESP_OKAY;
    end
    else
    begin
      awready_q <= w_take;
      if (w_take)
      begin
        bvalid_q <= 1'b1;
        bresp_q  <= w_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
        bvalid_q <= 1'b0;
      arready_q <= r_take;
      if (r_take)
      begin
        rvalid_q <= 1'b1;
        rresp_q  <= r_ok ? RESP_OKAY : RESP_SLVERR;
        rdata_q  <= !r_ok ? 32'h0000_0000 :
                    (s_axi_araddr == HOFS_ISSUE) ? issue_q : result;
      end
      else if (s_axi_rready)
        rvalid_q <= 1'b0;
    end
  end

  // link access engine
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      issue_q     <= 32'h0000_0000;
      pend_q      <= 1'b0;
      refused_q   <= 1'b0;
      stat_seen_q <= 8'h00;
      tf_rdata_q  <= 16'h0000;
      sel_q       <= SEL_DATA;
      wr_q        <= 1'b0;
      rd_q        <= 1'b0;
      wd_q        <= 16'h0000;
    end
    else
    begin
      wr_q <= go & ~new_rd;
      rd_q <= go & new_rd;
      if (w_issue)
      begin
        issue_q   <= s_axi_wdata;
        refused_q <= ~allowed;
      end
      if (go)
      begin
        sel_q  <= new_sel;
        wd_q   <= new_wd;
        pend_q <= new_rd;
      end
      else if (lnk.tf_ack)
      begin
        pend_q     <= 1'b0;
        tf_rdata_q <= lnk.tf_rdata;
        if (sel_q == SEL_STAT_CMD || sel_q == SEL_AUX_CTL)
          stat_seen_q <= lnk.tf_rdata[7:0];
      end
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready  = awready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign lnk.tf_sel    = sel_q;
  assign lnk.tf_wr     = wr_q;
  assign lnk.tf_rd     = rd_q;
  assign lnk.tf_wdata  = wd_q;
endmodule // tfr_host_end

// >>> test/tfr_link_monitor.sv
module tfr_link_monitor (
  // clock and reset
  input wire logic        core_clk,
  input wire logic        rst_n,
  // task-file link
  input wire logic [3:0]  tf_sel,
  input wire logic        tf_wr,
  input wire logic        tf_rd,
  input wire logic [15:0] tf_wdata,
  input wire logic [15:0] tf_rdata,
  input wire logic        tf_ack,
  input wire logic        tf_intrq
);
  timeunit 1ns;
  timeprecision 1ps;
  import tfr_pkg::*;

  logic srst_q;
  logic stat_ack;
  logic [3:0] sel_q;

  // soft reset bit as last written by the host, select of the last cycle
  always_ff @(posedge core_clk)
  begin
    sel_q <= tf_sel;
    if (!rst_n)
      srst_q <= 1'b0;
    else if (tf_wr && tf_sel == SEL_AUX_CTL)
      srst_q <= tf_wdata[CTL_SRST];
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  chk_ack_next_cycle: assert property (tf_rd |=> tf_ack)
    else $error("link read not answered in the next cycle");
  chk_err_zero_bits: assert property (
    tf_ack && $past(tf_sel) == SEL_ERR_FEAT |-> (tf_rdata & 16'hff2a) == 16'h0000)
    else $error("error register reserved bits not zero");
  assign stat_ack = tf_ack && (sel_q inside {SEL_STAT_CMD, SEL_AUX_CTL});
  chk_index_zero: assert property (stat_ack && !tf_rdata[7] |-> !tf_rdata[1])
    else $error("status index bit not zero");
  chk_seek_ready: assert property (stat_ack && tf_rdata[7:6] == 2'b01 |-> tf_rdata[4])
    else $error("seek complete missing while ready");
  chk_stat_clears: assert property (tf_rd && tf_sel == SEL_STAT_CMD |-> ##2 !tf_intrq)
    else $error("status read left interrupt pending");
  chk_aux_keeps: assert property (
    tf_rd && tf_sel == SEL_AUX_CTL && tf_intrq |=> tf_intrq [*2])
    else $error("aux status read dropped interrupt");
  chk_mask_drops: assert property (
    tf_wr && tf_sel == SEL_AUX_CTL && tf_wdata[CTL_NIEN] |-> ##2 !tf_intrq)
    else $error("interrupt stays with disable bit set");
  chk_dh_form: assert property (tf_wr && tf_sel == SEL_DRVHEAD |->
    tf_wdata[DH_ONE_HI] && tf_wdata[DH_ONE_LO] && !tf_wdata[DH_DRV])
    else $error("drive/head written with bad fixed bits");
  chk_no_legacy: assert property ((tf_rd || tf_wr) |-> tf_sel != SEL_DRV_ADDR)
    else $error("host touched legacy drive address");
  chk_srst_busy: assert property (stat_ack && srst_q |-> tf_rdata[STAT_BUSY])
    else $error("busy not shown during soft reset");
endmodule // tfr_link_monitor

// >>> test/tb_ata_task_file_register_set.sv
module tb_ata_task_file_register_set;
  timeunit 1ns;
  timeprecision 1ps;
  import tfr_pkg::*;

  logic        core_clk, rst_n, awv, awr, wv, wrdy, bv, br, arv, arr, rv, rr;
  logic [3:0]  awa, ara;
  logic [31:0] wd, rd, r, v;
  logic [1:0]  bresp, rresp, resp;
  logic        be_ready, be_wfault, be_done, be_corrected_error_flag, be_fill_we, be_req, be_lba_mode;
  logic        seen_mode;
  logic [4:0]  be_err, resp_err;
  logic [7:0]  be_fill_addr, be_drain_addr, be_cmd_code;
  logic [15:0] be_fill_data, be_drain_data;
  logic [27:0] be_lba, seen_lba;
  int          num_errors = 0;
  int          total_checks = 0;

  tfr_link_if lnk_if ();

  tfr_host_end i_tfr_host_end (.core_clk(core_clk), .rst_n(rst_n),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
    .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
    .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_bresp(bresp),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_rvalid(rv),
    .s_axi_rready(rr), .s_axi_rdata(rd), .s_axi_rresp(rresp), .lnk(lnk_if.host_mp));

  tfr_device_end i_tfr_device_end (.core_clk(core_clk), .rst_n(rst_n),
    .lnk(lnk_if.dev_mp), .be_ready(be_ready), .be_wfault(be_wfault),
    .be_done(be_done), .be_err(be_err), .be_corrected_error_flag(be_corrected_error_flag), .be_fill_we(be_fill_we),
    .be_fill_addr(be_fill_addr), .be_fill_data(be_fill_data),
    .be_drain_addr(be_drain_addr), .be_drain_data(be_drain_data), .be_req(be_req),
    .be_cmd_code(be_cmd_code), .be_lba(be_lba), .be_lba_mode(be_lba_mode),
    .be_feature());

  tfr_link_monitor i_tfr_link_monitor (.core_clk(core_clk), .rst_n(rst_n),
    .tf_sel(lnk_if.tf_sel), .tf_wr(lnk_if.tf_wr), .tf_rd(lnk_if.tf_rd),
    .tf_wdata(lnk_if.tf_wdata), .tf_rdata(lnk_if.tf_rdata), .tf_ack(lnk_if.tf_ack),
    .tf_intrq(lnk_if.tf_intrq));

  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // back end: fills the buffer for read command 8'h20 only, then ends the step
  initial
  begin
    {be_done, be_corrected_error_flag, be_fill_we, be_err, be_fill_addr, be_fill_data} = '0;
    forever
    begin
      @(posedge core_clk);
      if (be_req === 1'b1)
      begin
        seen_lba <= be_lba;
        seen_mode <= be_lba_mode;
        if (be_cmd_code == 8'h20)
          for (int i = 0; i < 256; i++)
          begin
            be_fill_we <= 1'b1;
            be_fill_addr <= 8'(i);
            be_fill_data <= 16'h5a00 ^ 16'(i);
            @(posedge core_clk);
          end
        be_fill_we <= 1'b0;
        repeat (4) @(posedge core_clk);
        be_done <= 1'b1;
        be_err <= resp_err;
        @(posedge core_clk);
        be_done <= 1'b0;
      end
    end
  end

  task automatic wrap_up();
    if (num_errors == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic give_up();
    $display("ERROR at %0t ns: wait limit reached", $time);
    num_errors++;
    wrap_up();
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("ERROR at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    int n;
    awv <= 1'b1;
    wv <= 1'b1;
    awa <= a;
    wd <= d;
    br <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge core_clk);
      if (awr) awv <= 1'b0;
      if (wrdy) wv <= 1'b0;
      if (bv) break;
    end
    if (n == 50) give_up();
    br <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] q, output logic [1:0] e);
    int n;
    arv <= 1'b1;
    ara <= a;
    rr <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge core_clk);
      if (arr) arv <= 1'b0;
      if (rv) break;
    end
    if (n == 50) give_up();
    q = rd;
    e = rresp;
    rr <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic lw(input logic [3:0] s, input logic [15:0] d);
    axi_wr(HOFS_ISSUE, {d, 7'h0, 1'b0, 4'h0, s});
  endtask

  task automatic lr(input logic [3:0] s, output logic [31:0] q);
    int n;
    axi_wr(HOFS_ISSUE, {16'h0, 7'h0, 1'b1, 4'h0, s});
    for (n = 0; n < 20; n++)
    begin
      axi_rd(HOFS_RESULT, r, resp);
      if (!r[0]) break;
    end
    if (n == 20) give_up();
    q = {16'h0, r[31:16]};
  endtask

  task automatic wait_stat(input logic [7:0] m, input logic [7:0] val);
    int n;
    for (n = 0; n < 200; n++)
    begin
      lr(SEL_AUX_CTL, v);
      if ((v[7:0] & m) == val) break;
    end
    if (n == 200) give_up();
  endtask

  task automatic put_sector();
    for (int i = 0; i < 256; i++)
      lw(SEL_DATA, 16'hc000 | 16'(i));
  endtask

  initial
  begin
    {rst_n, awv, wv, br, arv, rr, awa, ara, wd, be_ready, be_wfault} = '0;
    be_drain_addr = 8'h00;
    resp_err = 5'h00;
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    lr(SEL_AUX_CTL, v); check(v, 32'h00);
    lr(SEL_DRVHEAD, v); check(v, {24'h0, DH_RESET});
    be_ready <= 1'b1;
    lr(SEL_AUX_CTL, v); check(v, 32'h50);
    // command under write fault
    be_wfault <= 1'b1;
    lw(SEL_STAT_CMD, 16'h0030);
    lr(SEL_ERR_FEAT, v); check(v, 32'h04);
    lr(SEL_AUX_CTL, v); check(v, 32'h71);
    axi_rd(HOFS_RESULT, r, resp); check(r & 32'h4, 32'h4);
    lr(SEL_STAT_CMD, v); axi_rd(HOFS_RESULT, r, resp); check(r & 32'h4, 32'h0);
    be_wfault <= 1'b0;
    // block address and error layout
    lw(SEL_SECNUM, 16'h0012);
    lw(SEL_CYL_LO, 16'h0034);
    lw(SEL_CYL_HI, 16'h0056);
    lw(SEL_DRVHEAD, 16'h00e7);
    resp_err = 5'b11101;
    lw(SEL_STAT_CMD, 16'h0090);
    wait_stat(8'h80, 8'h00);
    check({4'h0, seen_lba}, 32'h7563412);
    check({31'h0, seen_mode}, 32'h1);
    lr(SEL_ERR_FEAT, v); check(v, 32'hd1);
    lr(SEL_STAT_CMD, v); check(v, 32'h51);
    // sector write in cylinder/head/sector mode
    lw(SEL_DRVHEAD, 16'h003f);
    lr(SEL_DRVHEAD, v); check(v, 32'haf);
    resp_err = 5'h00;
    lw(SEL_COUNT, 16'h0001);
    lw(SEL_STAT_CMD, 16'h0030);
    wait_stat(8'h88, 8'h08); check(v, 32'h58);
    put_sector();
    wait_stat(8'h80, 8'h00);
    check({31'h0, seen_mode}, 32'h0);
    lr(SEL_COUNT, v); check(v, 32'h00);
    be_drain_addr <= 8'h05;
    repeat (2) @(posedge core_clk);
    check({16'h0, be_drain_data}, 32'hc005);
    // high-order readback
    lw(SEL_COUNT, 16'h0011);
    lw(SEL_COUNT, 16'h0022);
    lw(SEL_AUX_CTL, 16'h0080);
    lr(SEL_COUNT, v); check(v, 32'h11);
    lw(SEL_SECNUM, 16'h0000);
    lr(SEL_COUNT, v); check(v, 32'h22);
    // sector read
    lw(SEL_COUNT, 16'h0001);
    lw(SEL_STAT_CMD, 16'h0020);
    wait_stat(8'h88, 8'h08);
    for (int i = 0; i < 256; i++)
    begin
      lr(SEL_DATA, v); check(v, {16'h0, 16'h5a00 ^ 16'(i)});
    end
    wait_stat(8'h80, 8'h00); check(v, 32'h50);
    // failing two-sector write
    resp_err = 5'b00001;
    lw(SEL_COUNT, 16'h0002);
    lw(SEL_STAT_CMD, 16'h0031);
    wait_stat(8'h88, 8'h08);
    put_sector();
    wait_stat(8'h80, 8'h00);
    lr(SEL_COUNT, v); check(v, 32'h02);
    // interrupt mask and soft reset
    axi_rd(HOFS_RESULT, r, resp); check(r & 32'h4, 32'h4);
    lw(SEL_AUX_CTL, 16'h0002);
    axi_rd(HOFS_RESULT, r, resp); check(r & 32'h4, 32'h0);
    lw(SEL_AUX_CTL, 16'h0004);
    lr(SEL_AUX_CTL, v); check(v & 32'hc0, 32'h80);
    lw(SEL_AUX_CTL, 16'h0079);
    wait_stat(8'hc0, 8'h40); check(v, 32'h50);
    // refused legacy select, unmapped address
    lr(SEL_DRV_ADDR, v); check(r & 32'h2, 32'h2);
    axi_rd(4'hc, r, resp); check({30'h0, resp}, {30'h0, RESP_SLVERR});
    wrap_up();
  end
endmodule // tb_ata_task_file_register_set
